// *** include/spiee_pkg.sv ***
/*
  Package of the serial EEPROM command port: opcodes, status layout,
  array geometry, self-timed write figures and the pin bundles.
  Assumes a 250 MHz system clock that samples every serial pin.
*/
package spiee_pkg;

  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned ADDR_W         = 12;
  localparam int unsigned MEM_DEPTH      = 4096;
  localparam int unsigned PAGE_W         = 5;

  // Opcodes.
  localparam logic [7:0]  OP_READ        = 8'h03;
  localparam logic [7:0]  OP_WRITE       = 8'h02;
  localparam logic [7:0]  OP_CLR_LATCH   = 8'h04;
  localparam logic [7:0]  OP_SET_LATCH   = 8'h06;
  localparam logic [7:0]  OP_STAT_READ   = 8'h05;
  localparam logic [7:0]  OP_STAT_WRITE  = 8'h01;

  // Status byte field positions.
  localparam int unsigned ST_PPE_BIT     = 7;
  localparam int unsigned ST_BG1_BIT     = 3;
  localparam int unsigned ST_BG0_BIT     = 2;
  localparam int unsigned ST_LATCH_BIT   = 1;
  localparam int unsigned ST_BUSY_BIT    = 0;

  // Reset values of the non-volatile status bits.
  localparam logic        PPE_RST        = 1'b0;
  localparam logic [1:0]  GUARD_RST      = 2'h0;

  // Guard boundaries.
  localparam logic [11:0] GUARD_QTR_BASE = 12'hC00;
  localparam logic [11:0] GUARD_HALF_BASE = 12'h800;

  // Self-timed write time, in microseconds, and its cycle count.
  localparam int unsigned TWC_US         = 5000;
  localparam int unsigned TWC_CYC        = TWC_US * CLK_MHZ;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } spiee_pins_t;

  typedef struct packed {
    logic so_o;
    logic so_oe;
  } spiee_so_t;

endpackage

// *** design/spiee_mem.sv ***
/*
  Byte-wide array store with one write and one registered read port.
  Assumes the caller never reads and writes the same word in one cycle.
*/
module spiee_mem #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 8
) (
  // Clock.
  input  wire logic          clk,
  input  wire logic          ce,
  // Write port.
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port.
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule

// *** design/spiee_port.sv ***
/*
  Serial command port of a 4096-byte EEPROM: shift logic, status byte,
  page buffer and self-timed programming.
  Assumes every pin is asynchronous to clk and slow next to it.
*/
// Contract
// R1 - Pin low plus enable bit locks status writes
// R2 - Pin fall never disturbs a running write
// R3 - Pin ignored while enable bit is zero
// R4 - Pause begins with clock low, else next fall
// R5 - Paused: ignore serial pins, keep partial command
// R6 - Release pause only with clock low
// R7 - Output floats whenever pause input low
// R8 - Host keeps pause high, select low per command
// R9 - Shift eight-bit instructions MSB first, rising edges
// R10 - Read: opcode, address, stream until deselect
// R11 - Read address increments, wraps at top
// R12 - Latch set only on deselect after eight bits
// R13 - Write up to 32 bytes in one page
// R14 - Load address wraps within the page
// R15 - Program only on deselect after full byte
// R16 - Status readable while busy, array not
// R17 - Decode read, write, status read opcodes
// R18 - Decode latch set, clear, status write opcodes
// R19 - Clear latch on reset, commands, write end
// R20 - Status byte layout with busy in bit 0
// R21 - Latch follows set/clear even when locked
// R22 - Guard bits changed only by status write
// R23 - Guard bits select protected array quarter; code protects top quarter (1), top half (2) or whole array (3)
// R24 - Output changes after fall, floats on deselect
// R25 - Self-timed write ends after bounded time
module spiee_port #(
  parameter int unsigned TWC_CYCLES = spiee_pkg::TWC_CYC
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 ce,
  // Serial pins.
  input  wire spiee_pkg::spiee_pins_t pins,
  output spiee_pkg::spiee_so_t      so,
  // Status view.
  output logic [7:0]                status_byte
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  spiee_pkg::spiee_pins_t s1_r, s2_r, s3_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      // Idle pin levels, so that no false clock edge follows reset.
      s1_r <= 5'h13;
      s2_r <= 5'h13;
      s3_r <= 5'h13;
    end else if (ce) begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  wire cs_n   = s2_r.cs_n;
  wire sck    = s2_r.sck;
  wire hold_n = s2_r.hold_n;
  wire wp_n   = s2_r.wp_n;
  wire rise   = sck & ~s3_r.sck;
  wire fall   = ~sck & s3_r.sck;
  wire desel  = cs_n & ~s3_r.cs_n;

  // ****************************************************************
  // Pause control
  // ****************************************************************
  typedef enum logic [2:0] {
    CMD    = 3'b001,
    ADDR   = 3'b010,
    DATA   = 3'b100
  } spiee_phase_t;

  localparam int unsigned ADDR_W_L = spiee_pkg::ADDR_W;

  logic         paused_r;
  logic         pend_r;
  spiee_phase_t ph_r;
  logic [4:0]   cnt_r;
  logic [7:0]   sh_r;
  logic [7:0]   op_r;
  logic [15:0]  addr_r;
  logic [7:0]   so_sh_r;
  logic         so_r;
  logic         drive_r;
  logic         latch_r;
  logic         ppe_r;
  logic [1:0]   guard_r;
  logic         busy_r;
  logic [31:0]  tmr_r;
  logic         full_r;
  logic         lat_arm_r;
  logic [7:0]   sw_data_r;
  logic         sw_pend_r;
  logic [7:0]   pbuf [0:31];
  logic [31:0]  pval_r;
  logic [ADDR_W_L-1:0] page_r;
  logic [4:0]   pidx_r;

  // Pause takes effect with clock low, or on the next fall; release only
  // with clock low.
  wire go_pause = ~hold_n & (~sck | fall);  // R4
  wire go_run   = hold_n & ~sck;            // R6
  wire active   = ~cs_n & ~paused_r;        // R5
  wire s_rise   = active & rise;            // R9
  wire s_fall   = active & fall;

  always_ff @(posedge clk) begin
    if (srst) begin
      paused_r <= 1'b0;
    end else if (ce) begin
      if (cs_n) begin
        paused_r <= 1'b0;
      end else if (!paused_r && go_pause) begin
        paused_r <= 1'b1;
      end else if (paused_r && go_run) begin
        paused_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Decode and protection
  // ****************************************************************
  wire is_read  = op_r == spiee_pkg::OP_READ;       // R17
  wire is_write = op_r == spiee_pkg::OP_WRITE;      // R17
  wire is_sread = op_r == spiee_pkg::OP_STAT_READ;  // R17
  wire is_sw    = op_r == spiee_pkg::OP_STAT_WRITE; // R18
  wire is_set   = op_r == spiee_pkg::OP_SET_LATCH;  // R18
  wire is_clr   = op_r == spiee_pkg::OP_CLR_LATCH;  // R18
  wire hw_lock  = ppe_r & ~wp_n;                    // R1 R3
  wire [11:0] wa = addr_r[11:0];
  wire guarded  = (guard_r == 2'h3) |                       // R23
                  (guard_r == 2'h2 && page_r >= spiee_pkg::GUARD_HALF_BASE) |
                  (guard_r == 2'h1 && page_r >= spiee_pkg::GUARD_QTR_BASE);
  wire byte_end = s_rise & (cnt_r == 5'h07);
  wire [7:0] sh_nxt = {sh_r[6:0], s2_r.si};          // R9

  // ****************************************************************
  // Command shifter
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      ph_r <= CMD;
      cnt_r <= 5'h00;
      sh_r <= 8'h00;
      op_r <= 8'h00;
      addr_r <= 16'h0000;
      full_r <= 1'b0;
      lat_arm_r <= 1'b0;
    end else if (ce) begin
      if (cs_n) begin
        ph_r <= CMD;
        cnt_r <= 5'h00;
        full_r <= 1'b0;
        lat_arm_r <= 1'b0;
      end else if (s_rise) begin
        sh_r <= sh_nxt;
        full_r <= 1'b0;
        lat_arm_r <= 1'b0;
        case (ph_r)
          CMD: begin
            cnt_r <= (cnt_r == 5'h07) ? 5'h00 : cnt_r + 5'h01;
            if (cnt_r == 5'h07) begin
              op_r <= sh_nxt;
              lat_arm_r <= (sh_nxt == spiee_pkg::OP_SET_LATCH) |  // R12
                           (sh_nxt == spiee_pkg::OP_CLR_LATCH);
              if (sh_nxt == spiee_pkg::OP_READ || sh_nxt == spiee_pkg::OP_WRITE) begin
                ph_r <= ADDR;  // R10
              end else begin
                ph_r <= DATA;
              end
            end
          end
          ADDR: begin
            addr_r <= {addr_r[14:0], s2_r.si};
            cnt_r <= (cnt_r == 5'h0F) ? 5'h00 : cnt_r + 5'h01;
            if (cnt_r == 5'h0F) begin
              ph_r <= DATA;
            end
          end
          DATA: begin
            cnt_r <= {2'h0, cnt_r[2:0] + 3'h1};
            if (cnt_r[2:0] == 3'h7) begin
              full_r <= 1'b1;                               // R15
              if (is_write) begin
                addr_r <= {4'h0, addr_r[11:5], addr_r[4:0] + 5'h01};  // R14
              end else if (is_read) begin
                addr_r <= {4'h0, addr_r[11:0] + 12'h001};             // R11
              end
            end
          end
          default: ph_r <= CMD;
        endcase
      end
    end
  end

  // ****************************************************************
  // Page buffer, status and self-timed write
  // ****************************************************************
  wire commit_w  = desel & full_r & is_write & latch_r & ~busy_r & ~guarded;  // R15
  wire commit_s  = desel & full_r & is_sw & latch_r & ~busy_r & ~hw_lock;    // R1
  wire load_byte = byte_end & (ph_r == DATA) & is_write & ~busy_r;
  wire prog_we   = busy_r & pval_r[pidx_r];
  wire [11:0] prog_a = {page_r[11:5], pidx_r};

  always_ff @(posedge clk) begin
    if (ce && load_byte) begin
      pbuf[wa[4:0]] <= sh_nxt;                              // R13
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      latch_r <= 1'b0;
      ppe_r <= spiee_pkg::PPE_RST;
      guard_r <= spiee_pkg::GUARD_RST;
      busy_r <= 1'b0;
      tmr_r <= 32'h0;
      pval_r <= 32'h0;
      page_r <= 12'h000;
      pidx_r <= 5'h00;
      sw_data_r <= 8'h00;
      sw_pend_r <= 1'b0;
    end else if (ce) begin
      if (load_byte) begin
        pval_r[wa[4:0]] <= 1'b1;
        page_r <= wa;
      end
      if (byte_end && ph_r == DATA && is_sw) begin
        sw_data_r <= sh_nxt;
      end
      if (commit_w || commit_s) begin
        busy_r <= 1'b1;
        tmr_r <= 32'h0;
        pidx_r <= 5'h00;
        sw_pend_r <= commit_s;
        latch_r <= 1'b0;                                      // R19
      end else if (busy_r) begin
        pidx_r <= pidx_r + 5'h01;                             // R2
        if (tmr_r == TWC_CYCLES - 1) begin
          busy_r <= 1'b0;                                     // R25
          latch_r <= 1'b0;                                    // R19
          pval_r <= 32'h0;
          if (sw_pend_r) begin
            ppe_r <= sw_data_r[spiee_pkg::ST_PPE_BIT];        // R22
            guard_r <= sw_data_r[spiee_pkg::ST_BG1_BIT:spiee_pkg::ST_BG0_BIT];
          end
        end else begin
          tmr_r <= tmr_r + 32'h1;
        end
      end else if (desel && is_write) begin
        pval_r <= 32'h0;
      end
      // Placed last so that a set command wins over the clear at write end.
      if (desel && lat_arm_r) begin
        latch_r <= is_set;                                    // R12 R21
      end
    end
  end

  // ****************************************************************
  // Array and serial output
  // ****************************************************************
  logic [7:0] rd_byte;

  spiee_mem #(
    .AW (spiee_pkg::ADDR_W),
    .DW (8)
  ) u_mem (
    .clk   (clk),
    .ce    (ce),
    .we    (prog_we),
    .waddr (prog_a),
    .wdata (pbuf[pidx_r]),
    .raddr (wa),
    .rdata (rd_byte)
  );

  assign status_byte = {ppe_r, 3'h0, guard_r, latch_r, busy_r};  // R20
  wire out_phase = (ph_r == DATA) & ((is_read & ~busy_r) | is_sread);  // R16
  wire [7:0] load_val = is_sread ? status_byte : rd_byte;
  wire load_now = s_fall & out_phase & (cnt_r[2:0] == 3'h0);

  always_ff @(posedge clk) begin
    if (srst) begin
      so_sh_r <= 8'h00;
      so_r <= 1'b0;
      drive_r <= 1'b0;
    end else if (ce) begin
      drive_r <= active & out_phase & hold_n;           // R7 R24
      if (load_now) begin
        so_r <= load_val[7];                            // R24
        so_sh_r <= {load_val[6:0], 1'b0};
      end else if (s_fall && out_phase) begin
        so_r <= so_sh_r[7];
        so_sh_r <= {so_sh_r[6:0], 1'b0};
      end
    end
  end

  assign so = '{so_o: so_r, so_oe: drive_r & ~cs_n & hold_n};  // R5 R7

endmodule

// *** testbench/spiee_chk.sv ***
/*
  Checker of the command port pins and status view.
  Assumes ce stays high and the port parameter is handed on by bind.
*/
module spiee_chk #(
  parameter int unsigned TWC_CYCLES = 200
) (
  // Clock and reset.
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic                   ce,
  // Serial side.
  input wire spiee_pkg::spiee_pins_t pins,
  input wire spiee_pkg::spiee_so_t   so,
  // Status view.
  input wire logic [7:0]             status_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] busy_cnt_r;
  wire         busy = status_byte[0];
  always_ff @(posedge clk) begin
    if (srst) busy_cnt_r <= 32'h0;
    else busy_cnt_r <= busy ? busy_cnt_r + 32'h1 : 32'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst || !ce);
  sequence hold_low4; !pins.hold_n [*4]; endsequence
  sequence desel4; pins.cs_n [*4]; endsequence
  a_so_hold_float: assert property (hold_low4 |-> !so.so_oe)
    else $error("SO driven while paused");
  a_so_desel_float: assert property (desel4 |-> !so.so_oe)
    else $error("SO driven while deselected");
  a_so_after_fall: assert property (so.so_oe && $past(so.so_oe) && $changed(so.so_o)
    |-> !pins.sck)
    else $error("SO changed with SCK high");
  a_busy_len_exact: assert property ($fell(busy)
    |-> busy_cnt_r >= TWC_CYCLES - 1 && busy_cnt_r <= TWC_CYCLES + 1)
    else $error("write time wrong");
  a_busy_bounded: assert property (busy_cnt_r <= TWC_CYCLES + 1)
    else $error("write never ends");
  a_busy_start: assert property ($rose(busy) |-> pins.cs_n && $past(status_byte[1]))
    else $error("write started without latch or deselect");
  a_latch_end_clr: assert property ($fell(busy) |-> ##[0:1] !status_byte[1])
    else $error("latch kept after write");
  a_latch_set_desel: assert property ($rose(status_byte[1]) |-> pins.cs_n)
    else $error("latch set while selected");
  a_guard_commit: assert property ($changed(status_byte[7:2])
    |-> $past(busy) || $past(busy, 2))
    else $error("status bits changed outside write end");
  a_stat_rsv_zero: assert property (status_byte[6:4] == 3'h0)
    else $error("status spare bits set");
  a_reset_zero: assert property ($fell(srst) |-> status_byte == 8'h00 && !so.so_oe)
    else $error("reset state wrong");
endmodule
bind spiee_port spiee_chk #(.TWC_CYCLES(TWC_CYCLES)) chk_u (.clk(clk), .srst(srst),
  .ce(ce), .pins(pins), .so(so), .status_byte(status_byte));

// *** testbench/spiee_host.sv ***
/*
  Behavioural host master for the command port.
  Assumes the bench calls its tasks one at a time.
*/
module spiee_host (
  // Clock.
  input wire logic                   clk,
  // Serial side.
  output spiee_pkg::spiee_pins_t     pins,
  input wire spiee_pkg::spiee_so_t   so
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;
  logic       tgl = 1'b0;
  logic [7:0] rx_b;
  event       rx_ev;
  // A released SO shows a changing level, so a stale value never passes.
  wire        so_w = so.so_oe ? so.so_o : tgl;
  always @(posedge clk) tgl <= ~tgl;
  initial pins = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  task automatic sel();
    @(posedge clk);
    #1 pins.cs_n = 1'b0;
    #HALF;
  endtask
  task automatic desel();
    #HALF pins.cs_n = 1'b1;
    #200;
  endtask
  task automatic xfer(input logic [7:0] tx, input int n, input bit chk);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      pins.si = tx[7 - i];
      #HALF pins.sck = 1'b1;
      r = {r[6:0], so_w};
      #HALF pins.sck = 1'b0;
    end
    rx_b = r;
    if (chk) -> rx_ev;
  endtask
  task automatic pause();
    pins.hold_n = 1'b0;
    repeat (3) begin
      #HALF pins.sck = 1'b1;
      pins.si = ~pins.si;
      #HALF pins.sck = 1'b0;
    end
    #HALF pins.hold_n = 1'b1;
  endtask
endmodule

// *** testbench/tb_top.sv ***
/*
  Self-checking bench of the command port.
  Assumes the host model drives every pin and reports each read byte.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TWC = 2000;
  logic                   clk = 1'b0;
  logic                   srst = 1'b1;
  spiee_pkg::spiee_pins_t pins;
  spiee_pkg::spiee_so_t   so;
  logic [7:0]             status_byte;
  int                     fails = 0;
  int                     comparisons = 0;
  logic [7:0]             exp_q[$];
  logic [7:0]             d[4];
  logic [3:0]             top;
  always #2 clk = ~clk;
  spiee_port #(.TWC_CYCLES(TWC)) dut_u (.clk(clk), .srst(srst), .ce(1'b1),
    .pins(pins), .so(so), .status_byte(status_byte));
  spiee_host host_u (.clk(clk), .pins(pins), .so(so));
  task automatic complete_run();
    fails += exp_q.size();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] a);
    comparisons++;
    if (a !== e) begin
      fails++;
      $display("[ERR] %0t read %h expected %h", $time, a, e);
    end
  endtask
  initial forever @(host_u.rx_ev) begin
    if (exp_q.size() == 0) begin
      fails++;
      $display("[ERR] %0t read byte with no expectation", $time);
    end else begin
      cmp_byte(exp_q.pop_front(), host_u.rx_b);
    end
  end
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  task automatic op(input logic [7:0] c);
    host_u.sel();
    host_u.xfer(c, 8, 1'b0);
    host_u.desel();
  endtask
  task automatic rd_stat(input logic [7:0] e);
    host_u.sel();
    host_u.xfer(spiee_pkg::OP_STAT_READ, 8, 1'b0);
    exp_q.push_back(e);
    host_u.xfer(8'h00, 8, 1'b1);
    host_u.desel();
  endtask
  task automatic cmd_addr(input logic [7:0] c, input logic [11:0] a);
    host_u.sel();
    host_u.xfer(c, 8, 1'b0);
    host_u.xfer({top, a[11:8]}, 8, 1'b0);
    host_u.xfer(a[7:0], 8, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e0, e1, input int n);
    cmd_addr(spiee_pkg::OP_READ, a);
    exp_q.push_back(e0);
    host_u.xfer(8'h00, 8, 1'b1);
    if (n > 1) begin
      exp_q.push_back(e1);
      host_u.xfer(8'h00, 8, 1'b1);
    end
    host_u.desel();
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] b0, b1, st);
    op(spiee_pkg::OP_SET_LATCH);
    cmd_addr(spiee_pkg::OP_WRITE, a);
    host_u.xfer(b0, 8, 1'b0);
    host_u.xfer(b1, 8, 1'b0);
    host_u.desel();
    rd_stat(st);
    #9000;
  endtask
  task automatic status_write_cmd(input logic [7:0] v);
    op(spiee_pkg::OP_SET_LATCH);
    host_u.sel();
    host_u.xfer(spiee_pkg::OP_STAT_WRITE, 8, 1'b0);
    host_u.xfer(v, 8, 1'b0);
    host_u.desel();
  endtask
  initial begin
    top = 4'($urandom(54));
    for (int i = 0; i < 4; i++) d[i] = 8'($urandom);
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    rd_stat(8'h00);
    host_u.sel();
    host_u.xfer(spiee_pkg::OP_STAT_READ, 4, 1'b0);
    host_u.pause();
    host_u.xfer({spiee_pkg::OP_STAT_READ[3:0], 4'h0}, 4, 1'b0);
    exp_q.push_back(8'h00);
    host_u.xfer(8'h00, 8, 1'b1);
    host_u.desel();
    op(spiee_pkg::OP_SET_LATCH);
    rd_stat(8'h02);
    op(spiee_pkg::OP_CLR_LATCH);
    rd_stat(8'h00);
    host_u.sel();
    host_u.xfer(spiee_pkg::OP_SET_LATCH, 8, 1'b0);
    host_u.xfer(spiee_pkg::OP_WRITE, 8, 1'b0);
    host_u.desel();
    rd_stat(8'h00);
    wr(12'h01F, d[0], d[1], 8'h01);
    wr(12'hFFF, d[2], d[3], 8'h01);
    rd(12'h01F, d[0], 8'h00, 1);
    rd(12'hFFF, d[2], d[1], 2);
    rd(12'hFE0, d[3], 8'h00, 1);
    op(spiee_pkg::OP_SET_LATCH);
    cmd_addr(spiee_pkg::OP_WRITE, 12'h000);
    host_u.xfer(~d[1], 8, 1'b0);
    host_u.xfer(8'hA5, 4, 1'b0);
    host_u.desel();
    op(spiee_pkg::OP_CLR_LATCH);
    rd(12'h000, d[1], 8'h00, 1);
    host_u.pins.wp_n = 1'b0;
    status_write_cmd(8'h84);
    #9000;
    rd_stat(8'h84);
    status_write_cmd(8'h00);
    #9000;
    rd_stat(8'h86);
    op(spiee_pkg::OP_CLR_LATCH);
    rd_stat(8'h84);
    wr(12'hFFF, ~d[2], ~d[3], 8'h86);
    op(spiee_pkg::OP_CLR_LATCH);
    rd(12'hFFF, d[2], 8'h00, 1);
    host_u.pins.wp_n = 1'b1;
    status_write_cmd(8'h00);
    host_u.pins.wp_n = 1'b0;
    #9000;
    rd_stat(8'h00);
    host_u.pins.wp_n = 1'b1;
    complete_run();
  end
endmodule
